/* rtl/mpcr_regs.sv */
// Purpose: Motor parameter register bank behind a two-wire serial target
// Assumes: Host writes register number high byte first, data MSB first
// Notes: Shadow words drive the control outputs; image words only store
`timescale 1ns/10ps
module mpcr_regs
    import mpcr_pkg::*;
#(
    parameter int unsigned PRECHARGE_SHORT_CYC = MPCR_PRECHARGE_SHORT_CYC,
    parameter int unsigned PRECHARGE_LONG_CYC = MPCR_PRECHARGE_LONG_CYC
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n_out,
    output mpcr_motor_model_t motor_model_out,
    output mpcr_startup_cmd_t startup_cmd_out,
    output logic lowpass_bypass_out,
    output logic [14:0] precharge_cycles_out,
    output logic [8:0] shunt_comp_value_out
);

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [2:0] scl_sync;
        logic [2:0] sda_sync;
        mpcr_fsm_t fsm;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic [1:0] byte_idx;
        logic [1:0] data_cnt;
        logic rnw;
        logic ack_seen;
        logic [15:0] addr;
        logic [31:0] word;
        logic sda_oe_n;
        logic sda_lvl;
        logic wr_pulse;
        logic [15:0] wr_addr;
        logic [31:0] wr_word;
        logic [31:0] mm_shadow;
        logic [31:0] sc_shadow;
        logic [31:0] mm_nvm;
        logic [31:0] sc_nvm;
        logic bypass;
        logic [14:0] precharge;
        logic [8:0] shunt_comp;
    } mpcr_state_t;

    mpcr_state_t s_q;
    mpcr_state_t s_d;

    // Read mux; unmapped numbers read zero
    function automatic logic [31:0] rd_word(input mpcr_state_t st,
                                            input logic [15:0] a);
        logic [31:0] r;
        r = 32'h00000000;
        case (a)
            MPCR_MM_SHADOW_ADDR: r = st.mm_shadow;
            MPCR_SC_SHADOW_ADDR: r = st.sc_shadow;
            MPCR_MM_NVM_ADDR: r = st.mm_nvm;
            MPCR_SC_NVM_ADDR: r = st.sc_nvm;
            default: r = 32'h00000000;
        endcase
        return r;
    endfunction : rd_word

    ////////////////////////////////////////////////////////////////////////
    // Pin conditioning: second flop is the first one logic may read
    logic scl;
    logic scl_prev;
    logic sda;
    logic sda_prev;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic [31:0] wdata;

    assign scl = s_q.scl_sync[1];
    assign scl_prev = s_q.scl_sync[2];
    assign sda = s_q.sda_sync[1];
    assign sda_prev = s_q.sda_sync[2];
    assign scl_rise = scl & ~scl_prev;
    assign scl_fall = ~scl & scl_prev;
    assign start_cond = scl & scl_prev & sda_prev & ~sda;
    assign stop_cond = scl & scl_prev & ~sda_prev & sda;
    assign wdata = {s_q.word[23:0], s_q.shreg};

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.scl_sync = {s_q.scl_sync[1:0], scl_in};
        s_d.sda_sync = {s_q.sda_sync[1:0], sda_in};
        s_d.wr_pulse = 1'b0;
        if (start_cond) begin
            // Start or repeated start: address phase again, number kept
            s_d.fsm = MPCR_RX;
            s_d.bit_cnt = 4'h0;
            s_d.byte_idx = 2'h0;
            s_d.sda_oe_n = 1'b1;
        end else if (stop_cond) begin
            s_d.fsm = MPCR_IDLE;
            s_d.sda_oe_n = 1'b1;
        end else begin
            case (s_q.fsm)
                MPCR_RX: begin
                    if (scl_rise) begin
                        s_d.shreg = {s_q.shreg[6:0], sda};
                        s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                    end else if (scl_fall &&
                                 s_q.bit_cnt == MPCR_BITS_PER_BYTE) begin
                        s_d.bit_cnt = 4'h0;
                        s_d.fsm = MPCR_ACK;
                        s_d.sda_oe_n = 1'b0;
                        case (s_q.byte_idx)
                            2'h0: begin
                                s_d.rnw = s_q.shreg[0];
                                s_d.byte_idx = 2'h1;
                                if (s_q.shreg[7:1] != MPCR_DEV_ADDR) begin
                                    s_d.fsm = MPCR_IDLE; // Not ours
                                    s_d.sda_oe_n = 1'b1;
                                end
                            end
                            2'h1: begin
                                s_d.addr[15:8] = s_q.shreg;
                                s_d.byte_idx = 2'h2;
                            end
                            2'h2: begin
                                s_d.addr[7:0] = s_q.shreg;
                                s_d.byte_idx = 2'h3;
                                s_d.data_cnt = 2'h0;
                            end
                            default: begin
                                s_d.word = wdata;
                                s_d.data_cnt = s_q.data_cnt + 2'h1;
                                if (s_q.data_cnt == MPCR_LAST_DATA_BYTE) begin
                                    // Fourth byte: commit and step on
                                    s_d.wr_pulse = 1'b1;
                                    s_d.wr_addr = s_q.addr;
                                    s_d.wr_word = wdata;
                                    s_d.addr = s_q.addr + 16'h0001;
                                    case (s_q.addr)
                                        MPCR_MM_SHADOW_ADDR:
                                            s_d.mm_shadow = wdata &
                                                MPCR_MM_MASK;
                                        MPCR_SC_SHADOW_ADDR:
                                            s_d.sc_shadow = wdata &
                                                MPCR_SC_MASK;
                                        MPCR_MM_NVM_ADDR:
                                            s_d.mm_nvm = wdata &
                                                MPCR_MM_MASK;
                                        MPCR_SC_NVM_ADDR:
                                            s_d.sc_nvm = wdata &
                                                MPCR_SC_MASK;
                                        default: s_d.wr_pulse = 1'b0;
                                    endcase
                                end
                            end
                        endcase
                    end
                end
                MPCR_ACK: begin
                    if (scl_fall) begin
                        s_d.sda_oe_n = 1'b1;
                        s_d.fsm = MPCR_RX;
                        if (s_q.rnw) begin
                            // Read: load the word, present its top bit
                            s_d.word = rd_word(s_q, s_q.addr);
                            s_d.sda_oe_n = s_d.word[31];
                            s_d.data_cnt = 2'h0;
                            s_d.fsm = MPCR_TX;
                        end
                    end
                end
                MPCR_TX: begin
                    if (scl_fall) begin
                        s_d.word = {s_q.word[30:0], 1'b0};
                        s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                        s_d.sda_oe_n = s_d.word[31];
                        if (s_q.bit_cnt == MPCR_BITS_PER_BYTE - 4'h1) begin
                            s_d.bit_cnt = 4'h0;
                            s_d.sda_oe_n = 1'b1; // Host acknowledges
                            s_d.ack_seen = 1'b0;
                            s_d.fsm = MPCR_MACK;
                        end
                    end
                end
                MPCR_MACK: begin
                    if (scl_rise) begin
                        s_d.ack_seen = ~sda;
                        if (sda) begin
                            s_d.fsm = MPCR_IDLE; // Host ends the read
                        end
                    end else if (scl_fall && s_q.ack_seen) begin
                        s_d.data_cnt = s_q.data_cnt + 2'h1;
                        if (s_q.data_cnt == MPCR_LAST_DATA_BYTE) begin
                            s_d.addr = s_q.addr + 16'h0001;
                            s_d.word = rd_word(s_q, s_d.addr);
                        end
                        s_d.sda_oe_n = s_d.word[31];
                        s_d.fsm = MPCR_TX;
                    end
                end
                default: begin
                    s_d.fsm = MPCR_IDLE;
                    s_d.sda_oe_n = 1'b1;
                end
            endcase
        end
        // Derived controls follow the shadow words
        s_d.bypass = (s_d.sc_shadow[2:0] == 3'h0);
        s_d.precharge = s_d.sc_shadow[23] ?
            15'(PRECHARGE_LONG_CYC) : 15'(PRECHARGE_SHORT_CYC);
        s_d.shunt_comp = {s_d.sc_shadow[31:24], 1'b0};
        s_d.sda_lvl = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            s_q <= '0;
            s_q.scl_sync <= 3'h7;
            s_q.sda_sync <= 3'h7;
            s_q.fsm <= MPCR_IDLE;
            s_q.sda_oe_n <= 1'b1;
            s_q.mm_shadow <= MPCR_WORD_RESET;
            s_q.sc_shadow <= MPCR_WORD_RESET;
            s_q.mm_nvm <= MPCR_WORD_RESET;
            s_q.sc_nvm <= MPCR_WORD_RESET;
            s_q.bypass <= 1'b1;
            s_q.precharge <= 15'(PRECHARGE_SHORT_CYC);
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs from state flops
    assign sda_out = s_q.sda_lvl;
    assign sda_oe_n_out = s_q.sda_oe_n;
    assign motor_model_out = mpcr_motor_model_t'(s_q.mm_shadow);
    assign startup_cmd_out = mpcr_startup_cmd_t'(s_q.sc_shadow);
    assign lowpass_bypass_out = s_q.bypass;
    assign precharge_cycles_out = s_q.precharge;
    assign shunt_comp_value_out = s_q.shunt_comp;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic wr_mm;
    logic wr_sc;
    assign wr_mm = s_q.wr_pulse && s_q.wr_addr == MPCR_MM_SHADOW_ADDR;
    assign wr_sc = s_q.wr_pulse && s_q.wr_addr == MPCR_SC_SHADOW_ADDR;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);

    AST_RS_FIELDS: assert property (wr_mm |->
        motor_model_out.winding_resistance_mantissa == s_q.wr_word[11:0] &&
        motor_model_out.winding_resistance_exponent == s_q.wr_word[14:12])
        else $error("resistance fields do not hold written value");
    AST_KE_FIELDS: assert property (wr_mm |->
        motor_model_out.backemf_constant_mantissa == s_q.wr_word[27:16] &&
        motor_model_out.backemf_constant_exponent == s_q.wr_word[30:28])
        else $error("back-EMF fields do not hold written value");
    AST_TAU_BYPASS: assert property (wr_sc |->
        (lowpass_bypass_out == (s_q.wr_word[2:0] == 3'h0)) &&
        startup_cmd_out.command_lowpass_tau == s_q.wr_word[2:0])
        else $error("filter bypass does not follow tau field");
    AST_SPIN_DIR: assert property (wr_sc |->
        startup_cmd_out.spin_direction_reverse == s_q.wr_word[3])
        else $error("spin direction bit wrong");
    AST_AVERAGE: assert property (wr_sc |->
        startup_cmd_out.command_averaging_on == s_q.wr_word[4])
        else $error("averaging bit wrong");
    AST_STAND_ANGLE: assert property (wr_sc |->
        startup_cmd_out.standstill_advance_angle == s_q.wr_word[7:5])
        else $error("standstill angle wrong");
    AST_IDENT_EN: assert property (wr_sc |->
        startup_cmd_out.pulse_ident_enable == s_q.wr_word[8])
        else $error("identification enable wrong");
    AST_IDENT_LEN: assert property (wr_sc |->
        startup_cmd_out.pulse_ident_length == s_q.wr_word[11:9])
        else $error("identification length wrong");
    AST_IDENT_RATE: assert property (wr_sc |->
        startup_cmd_out.pulse_ident_rate == s_q.wr_word[17:12])
        else $error("identification rate wrong");
    AST_SPIN_ANGLE: assert property (wr_sc |->
        startup_cmd_out.spinning_start_advance_angle == s_q.wr_word[20:18])
        else $error("spinning start angle wrong");
    AST_ALIGN_ANGLE: assert property (wr_sc |->
        startup_cmd_out.align_start_angle == s_q.wr_word[22:21])
        else $error("align angle wrong");
    AST_PRECHARGE: assert property ($changed(startup_cmd_out.precharge_long)
        |-> precharge_cycles_out == (startup_cmd_out.precharge_long ?
            15'(PRECHARGE_LONG_CYC) : 15'(PRECHARGE_SHORT_CYC)))
        else $error("precharge count does not follow select bit");
    AST_SHUNT_COMP: assert property ($stable(s_q.sc_shadow) [*2] |->
        shunt_comp_value_out == {startup_cmd_out.shunt_current_comp,
            1'b0})
        else $error("shunt compensation is not twice the field");
    AST_RSVD_ZERO: assert property (s_q.wr_pulse |=>
        s_q.mm_shadow[31] == 1'b0 && s_q.mm_shadow[15] == 1'b0 &&
        s_q.mm_nvm[31] == 1'b0 && s_q.mm_nvm[15] == 1'b0)
        else $error("unassigned bits do not read zero");

    COV_WRITE_MM: cover property (wr_mm);
    COV_WRITE_SC: cover property (wr_sc ##1 startup_cmd_out.precharge_long);
    COV_READ_BYTE: cover property (s_q.fsm == MPCR_TX ##[1:400]
        s_q.fsm == MPCR_MACK);
    COV_NACK_END: cover property (s_q.fsm == MPCR_MACK ##1
        s_q.fsm == MPCR_IDLE);

endmodule : mpcr_regs

/* include/mpcr_pkg.sv */
// Purpose: Shared constants and types for the motor parameter register bank
// Assumes: 200 MHz system clock; two-wire serial port gives register access
// Notes: Word addresses are the register numbers seen on the serial port
package mpcr_pkg;

    // Register numbers on the serial port
    localparam logic [15:0] MPCR_MM_SHADOW_ADDR = 16'h046F;
    localparam logic [15:0] MPCR_SC_SHADOW_ADDR = 16'h0470;
    localparam logic [15:0] MPCR_MM_NVM_ADDR = 16'h04CF;
    localparam logic [15:0] MPCR_SC_NVM_ADDR = 16'h04D0;

    // Serial target address; the value is arbitrary
    localparam logic [6:0] MPCR_DEV_ADDR = 7'h2A;

    // Writable bits per word; everything else reads zero
    localparam logic [31:0] MPCR_MM_MASK = 32'h7FFF7FFF;
    localparam logic [31:0] MPCR_SC_MASK = 32'hFFFFFFFF;
    localparam logic [31:0] MPCR_WORD_RESET = 32'h00000000;

    // Precharge timing
    localparam int unsigned MPCR_CLK_PERIOD_PS = 5000;
    localparam int unsigned MPCR_PRECHARGE_SHORT_US = 36;
    localparam int unsigned MPCR_PRECHARGE_LONG_US = 72;
    localparam int unsigned MPCR_PRECHARGE_SHORT_CYC =
        (MPCR_PRECHARGE_SHORT_US * 1000000) / MPCR_CLK_PERIOD_PS;
    localparam int unsigned MPCR_PRECHARGE_LONG_CYC =
        (MPCR_PRECHARGE_LONG_US * 1000000) / MPCR_CLK_PERIOD_PS;

    // Serial bit and byte counts
    localparam logic [3:0] MPCR_BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] MPCR_LAST_DATA_BYTE = 2'h3;

    // Motor model word layout
    typedef struct packed {
        logic rsvd_31;
        logic [2:0] backemf_constant_exponent;
        logic [11:0] backemf_constant_mantissa;
        logic rsvd_15;
        logic [2:0] winding_resistance_exponent;
        logic [11:0] winding_resistance_mantissa;
    } mpcr_motor_model_t;

    // Startup and command word layout
    typedef struct packed {
        logic [7:0] shunt_current_comp;
        logic precharge_long;
        logic [1:0] align_start_angle;
        logic [2:0] spinning_start_advance_angle;
        logic [5:0] pulse_ident_rate;
        logic [2:0] pulse_ident_length;
        logic pulse_ident_enable;
        logic [2:0] standstill_advance_angle;
        logic command_averaging_on;
        logic spin_direction_reverse;
        logic [2:0] command_lowpass_tau;
    } mpcr_startup_cmd_t;

    // Serial engine states, one-hot
    typedef enum logic [4:0] {
        MPCR_IDLE = 5'h01,
        MPCR_RX = 5'h02,
        MPCR_ACK = 5'h04,
        MPCR_TX = 5'h08,
        MPCR_MACK = 5'h10
    } mpcr_fsm_t;

endpackage : mpcr_pkg

/* test/mpcr_host.sv */
////////////////////////////////////////////////////////////////////////////
// Purpose: Two-wire serial host model driving the register bank pins
// Assumes: Open-drain data line with pull-up; host owns the serial clock
// Notes: Each clock phase lasts at least HALF system cycles (bit low phase HALF+2), above the 8 required
////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module mpcr_host #(
    parameter int HALF = 10
) (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_oe_n_out
);
    // Idle bus: clock high, data released
    initial begin
        scl_out = 1'b1;
        sda_oe_n_out = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin sequencing; every change lands just after a system clock edge
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_in);
    endtask : wait_clk

    // Start or repeated start: data falls while the clock is high
    task automatic send_start();
        sda_oe_n_out <= 1'b1;
        wait_clk(HALF);
        scl_out <= 1'b1;
        wait_clk(HALF);
        sda_oe_n_out <= 1'b0;
        wait_clk(HALF);
        scl_out <= 1'b0;
        wait_clk(HALF);
    endtask : send_start

    // Stop: data rises while the clock is high
    task automatic send_stop();
        sda_oe_n_out <= 1'b0;
        wait_clk(HALF);
        scl_out <= 1'b1;
        wait_clk(HALF);
        sda_oe_n_out <= 1'b1;
        wait_clk(HALF);
    endtask : send_stop

    // One bit; data held across the high phase, sampled before the fall
    task automatic xfer_bit(input logic b, output logic r);
        sda_oe_n_out <= b;
        wait_clk(HALF);
        scl_out <= 1'b1;
        wait_clk(HALF);
        r = sda_in;
        scl_out <= 1'b0;
        wait_clk(2);
    endtask : xfer_bit

    // Byte out, MSB first, then the target's acknowledge bit
    task automatic send_byte(input logic [7:0] d, output logic ack_n);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(d[i], r);
        end
        xfer_bit(1'b1, ack_n);
    endtask : send_byte

    // Byte in, MSB first; host acks unless this is the last byte
    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, r);
            d[i] = r;
        end
        xfer_bit(last, r);
    endtask : recv_byte
endmodule : mpcr_host

/* test/mpcr_regs_tb.sv */
////////////////////////////////////////////////////////////////////////////
// Purpose: Self-checking bench for the motor parameter register bank
// Assumes: Host model owns the serial pins; data line has a pull-up
// Notes: Precharge counts shortened to 36 and 72 cycles
////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) begin \
            n_errors++; \
            $display("BAD %s exp %h got %h", nm, (exp), (got)); \
        end \
    end
module mpcr_regs_tb
    import mpcr_pkg::*;
;
    localparam int P_SHORT = 36;
    localparam int P_LONG = 72;
    logic clk;
    logic reset_n;
    logic scl;
    logic host_oe_n;
    logic sda_w;
    logic sda_dev;
    logic dev_oe_n;
    mpcr_motor_model_t mm;
    mpcr_startup_cmd_t sc;
    logic bypass;
    logic [14:0] pre_cyc;
    logic [8:0] shunt;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic [31:0] v;
    logic ack_n;
    logic [31:0] vals [4] = '{32'hFFFFFFFF, 32'h12345678, 32'h5A5AA5A5,
        32'hEDCBA987};

    // Open-drain data line: anyone pulling wins, else the pull-up
    assign sda_w = !host_oe_n ? 1'b0 : (!dev_oe_n ? sda_dev : 1'b1);

    mpcr_regs #(
        .PRECHARGE_SHORT_CYC(P_SHORT),
        .PRECHARGE_LONG_CYC(P_LONG)
    ) uut (
        .clk_sys_in(clk),
        .reset_n_in(reset_n),
        .scl_in(scl),
        .sda_in(sda_w),
        .sda_out(sda_dev),
        .sda_oe_n_out(dev_oe_n),
        .motor_model_out(mm),
        .startup_cmd_out(sc),
        .lowpass_bypass_out(bypass),
        .precharge_cycles_out(pre_cyc),
        .shunt_comp_value_out(shunt)
    );

    mpcr_host host (
        .clk_in(clk),
        .sda_in(sda_w),
        .scl_out(scl),
        .sda_oe_n_out(host_oe_n)
    );

    // 200 MHz system clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_errors++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Closing report
    task automatic give_verdict();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    // Reset held six cycles, then time for the pin synchronisers
    task automatic do_reset();
        reset_n <= 1'b0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : do_reset

    // Byte that the target must acknowledge
    task automatic wb(input logic [7:0] b);
        logic a;
        host.send_byte(b, a);
        `CHK("ack", 1'b0, a)
    endtask : wb

    task automatic reg_write(input logic [15:0] a, input logic [31:0] d);
        host.send_start();
        wb({MPCR_DEV_ADDR, 1'b0});
        wb(a[15:8]);
        wb(a[7:0]);
        for (int i = 3; i >= 0; i--) begin
            wb(d[8*i +: 8]);
        end
        host.send_stop();
    endtask : reg_write

    task automatic reg_read(input logic [15:0] a, output logic [31:0] d);
        logic [7:0] b;
        host.send_start();
        wb({MPCR_DEV_ADDR, 1'b0});
        wb(a[15:8]);
        wb(a[7:0]);
        host.send_start();
        wb({MPCR_DEV_ADDR, 1'b1});
        for (int i = 3; i >= 0; i--) begin
            host.recv_byte(i == 0, b);
            d = {d[23:0], b};
        end
        host.send_stop();
    endtask : reg_read

    // Motor model outputs against the written word
    task automatic check_mm(input logic [31:0] w);
        `CHK("mm_word", w & MPCR_MM_MASK, mm)
        `CHK("res_m", w[11:0], mm.winding_resistance_mantissa)
        `CHK("res_e", w[14:12], mm.winding_resistance_exponent)
        `CHK("emf_m", w[27:16], mm.backemf_constant_mantissa)
        `CHK("emf_e", w[30:28], mm.backemf_constant_exponent)
    endtask : check_mm

    // Startup outputs and derived values against the written word
    task automatic check_sc(input logic [31:0] w);
        `CHK("sc_word", w, sc)
        `CHK("tau", w[2:0], sc.command_lowpass_tau)
        `CHK("bypass", (w[2:0] == 3'h0), bypass)
        `CHK("spin", w[3], sc.spin_direction_reverse)
        `CHK("avg", w[4], sc.command_averaging_on)
        `CHK("stand", w[7:5], sc.standstill_advance_angle)
        `CHK("id_en", w[8], sc.pulse_ident_enable)
        `CHK("id_len", w[11:9], sc.pulse_ident_length)
        `CHK("id_rate", w[17:12], sc.pulse_ident_rate)
        `CHK("spin_adv", w[20:18], sc.spinning_start_advance_angle)
        `CHK("align", w[22:21], sc.align_start_angle)
        `CHK("pre", w[23] ? 15'(P_LONG) : 15'(P_SHORT), pre_cyc)
        `CHK("shunt", {w[31:24], 1'b0}, shunt)
    endtask : check_sc

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        reset_n = 1'b0;
        @(posedge clk);
        do_reset();
        check_mm(32'h00000000);
        check_sc(32'h00000000);
        // Shadow words: outputs follow, readback masks reserved bits
        foreach (vals[k]) begin
            v = vals[k];
            reg_write(MPCR_MM_SHADOW_ADDR, v);
            reg_write(MPCR_SC_SHADOW_ADDR, ~v);
            check_mm(v);
            check_sc(~v);
            reg_read(MPCR_MM_SHADOW_ADDR, rd);
            `CHK("mm_rd", v & MPCR_MM_MASK, rd)
            reg_read(MPCR_SC_SHADOW_ADDR, rd);
            `CHK("sc_rd", ~v, rd)
        end
        // Image words store only and leave the outputs alone
        reg_write(MPCR_MM_NVM_ADDR, 32'hFFFFFFFF);
        reg_write(MPCR_SC_NVM_ADDR, 32'h13579BDF);
        reg_read(MPCR_MM_NVM_ADDR, rd);
        `CHK("mm_nvm", 32'h7FFF7FFF, rd)
        reg_read(MPCR_SC_NVM_ADDR, rd);
        `CHK("sc_nvm", 32'h13579BDF, rd)
        check_mm(v);
        check_sc(~v);
        // Unmapped number: write dropped, read gives zero
        reg_write(16'h0471, 32'hFFFFFFFF);
        reg_read(16'h0471, rd);
        `CHK("unmapped", 32'h00000000, rd)
        // Foreign target address is not acknowledged
        host.send_start();
        host.send_byte({~MPCR_DEV_ADDR, 1'b0}, ack_n);
        `CHK("nack", 1'b1, ack_n)
        host.send_stop();
        // Half a data word then stop: word must not change
        host.send_start();
        wb({MPCR_DEV_ADDR, 1'b0});
        wb(MPCR_SC_SHADOW_ADDR[15:8]);
        wb(MPCR_SC_SHADOW_ADDR[7:0]);
        wb(8'hFF);
        wb(8'hFF);
        host.send_stop();
        check_sc(~v);
        // Second reset clears every word
        do_reset();
        check_mm(32'h00000000);
        check_sc(32'h00000000);
        reg_read(MPCR_SC_NVM_ADDR, rd);
        `CHK("nvm_rst", 32'h00000000, rd)
        give_verdict();
    end
endmodule : mpcr_regs_tb
